/* File: rtl/lacc_map.vh */
`ifndef LACC_MAP_VH
`define LACC_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define LACC_CTRL_ADDR      8'h00
`define LACC_STATUS_ADDR    8'h04

// ----------------------------------------------------------------
// Control word fields and reset value
// ----------------------------------------------------------------
`define LACC_TRIM_LSB       0
`define LACC_TRIM_MSB       6
`define LACC_FILT_BIT       7
`define LACC_LOWER_LSB      8
`define LACC_LOWER_MSB      11
`define LACC_UPPERW_LSB     12
`define LACC_UPPERW_MSB     15
`define LACC_UPSTEP_LSB     16
`define LACC_UPSTEP_MSB     17
`define LACC_DNRATE_LSB     18
`define LACC_DNRATE_MSB     19
`define LACC_MINHALF_BIT    20
`define LACC_CS_LSB         21
`define LACC_CS_MSB         25
`define LACC_CTRL_MASK      32'h03FF_FFFF
`define LACC_CTRL_RST       32'h03E0_0000

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define LACC_ST_LOAD_LSB    0
`define LACC_ST_LOAD_MSB    9
`define LACC_ST_LEVEL_LSB   10
`define LACC_ST_LEVEL_MSB   14
`define LACC_ST_STALL_BIT   15

// ----------------------------------------------------------------
// Measurement constants
// ----------------------------------------------------------------
`define LACC_BAND_SHIFT     5
`define LACC_TRIM_SHIFT     3
`define LACC_FILT_LEN       4
`define LACC_LOAD_MAX       10'h3FF
`define LACC_LEVEL_RST      5'h1F
`define LACC_DN_CNT_R0      6'h20
`define LACC_DN_CNT_R1      6'h08
`define LACC_DN_CNT_R2      6'h02
`define LACC_DN_CNT_R3      6'h01

`endif

/* File: rtl/lacc_top.v */
// Summary of operation
// R1: Unfiltered: refresh load value every full step
// R2: Filter on: average four measurements per update
// R3: Below lower band times 32: raise current
// R4: Upper threshold is (lower+width+1) times 32
// R5: Lower current only after repeated high readings; at down-rate 3 the code lowers after a single one
// R6: Stall output high when load value zero
// R7: Trim level is signed, zero is neutral
// R8: Load value is 10-bit, low means heavy
// R9: Raise step is 1, 2, 4 or 8
// R10: Lower once per 32, 8, 2, 1 readings
// R11: Current kept between CS/2 or CS/4 and CS
// R12: Stall output low while load value nonzero
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`include "lacc_map.vh"

module lacc_top #(
    parameter ADDR_W = 8
) (
    input  wire              clk,
    input  wire              rstn,
    // Wishbone classic slave
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [ADDR_W-1:0] wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [31:0]       wb_dat_i,
    output reg  [31:0]       wb_dat_o,
    output reg               wb_ack_o,
    // Motor side
    input  wire              fullStep,
    input  wire [9:0]        rawLoad,
    output reg  [9:0]        loadValue,
    output reg  [4:0]        actualCurrentLevel,
    output reg               stallOutput
);

    // ------------------------------------------------------------
    // Control word and its fields
    // ------------------------------------------------------------
    // Control word layout
    //   [6:0]   signed trim, scaled by 8
    //   [7]     filter on
    //   [11:8]  lower band
    //   [15:12] upper band width
    //   [17:16] up-step select
    //   [19:18] down-rate select
    //   [20]    floor at a quarter of the scale
    //   [25:21] configured scale, also the ceiling
    // Status word layout
    //   [9:0]   load value
    //   [14:10] adapted level
    //   [15]    stall
    reg  [31:0] ctrl_r;
    reg  [31:0] ctrl_nxt;

    // Field views of the control word
    wire [6:0]  loadTrimLevel  = ctrl_r[`LACC_TRIM_MSB:`LACC_TRIM_LSB];
    wire        loadFilterOn   = ctrl_r[`LACC_FILT_BIT];
    wire [3:0]  lowerBand      = ctrl_r[`LACC_LOWER_MSB:`LACC_LOWER_LSB];
    wire [3:0]  upperBandWidth = ctrl_r[`LACC_UPPERW_MSB:`LACC_UPPERW_LSB];
    wire [1:0]  upStepWidth    = ctrl_r[`LACC_UPSTEP_MSB:`LACC_UPSTEP_LSB];
    wire [1:0]  downRateCount  = ctrl_r[`LACC_DNRATE_MSB:`LACC_DNRATE_LSB];
    wire        minCurrentHalf = ctrl_r[`LACC_MINHALF_BIT];
    wire [4:0]  currentScale   = ctrl_r[`LACC_CS_MSB:`LACC_CS_LSB];

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Readings at or above upper band needed per decrement
    // Slow down, fast up: a late decrement only costs power
    function [5:0] downLimit;
        input [1:0] rate;
        begin
            case (rate)
                2'd0:    downLimit = `LACC_DN_CNT_R0;
                2'd1:    downLimit = `LACC_DN_CNT_R1;
                2'd2:    downLimit = `LACC_DN_CNT_R2;
                default: downLimit = `LACC_DN_CNT_R3;
            endcase
        end
    endfunction

    // Clamp a widened level into [lo, hi]
    // Widened by one bit so an overshooting raise still clamps
    function [4:0] clampLevel;
        input [5:0] val;
        input [4:0] lo;
        input [4:0] hi;
        begin
            if (val > {1'b0, hi}) begin
                clampLevel = hi;
            end else if (val < {1'b0, lo}) begin
                clampLevel = lo;
            end else begin
                clampLevel = val[4:0];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Trimmed measurement
    // ------------------------------------------------------------
    // Signed trim shifts the raw reading; negative trim makes stall
    // show earlier, zero leaves the reading untouched
    // Trim spans -64..63, moving the reading by -512..504
    wire signed [11:0] trimOffset = {{2{loadTrimLevel[6]}}, loadTrimLevel,
                                     3'b000};                    // see R7
    wire signed [11:0] trimSum    = $signed({2'b00, rawLoad}) + trimOffset;
    reg         [9:0]  trimmedLoad;

    // Saturate into the 10-bit unsigned range
    always @* begin
        if (trimSum[11]) begin
            trimmedLoad = 10'h000;
        end else if (trimSum[10]) begin
            trimmedLoad = `LACC_LOAD_MAX;                        // see R8
        end else begin
            trimmedLoad = trimSum[9:0];
        end
    end

    // ------------------------------------------------------------
    // Load value update, plain or filtered
    // ------------------------------------------------------------
    reg  [1:0]  filtCnt_r;
    reg  [11:0] filtSum_r;
    reg         measDone_r;
    wire [11:0] filtTotal = filtSum_r + {2'b00, trimmedLoad};

    // Filtering trades response time for precision: one result per
    // four full steps. Toggling the filter bit restarts the window.
    // Sum of four 10-bit readings needs twelve bits
    // Filter state is cleared while the filter is off
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            filtCnt_r  <= 2'd0;
            filtSum_r  <= 12'h000;
            loadValue  <= `LACC_LOAD_MAX;
            measDone_r <= 1'b0;
        end else begin
            measDone_r <= 1'b0;
            if (!loadFilterOn) begin
                filtCnt_r <= 2'd0;
                filtSum_r <= 12'h000;
                if (fullStep) begin
                    loadValue  <= trimmedLoad;                   // see R1
                    measDone_r <= 1'b1;
                end
            end else if (fullStep) begin
                if (filtCnt_r == 2'd3) begin
                    loadValue  <= filtTotal[11:2];               // see R2
                    measDone_r <= 1'b1;
                    filtCnt_r  <= 2'd0;
                    filtSum_r  <= 12'h000;
                end else begin
                    filtCnt_r <= filtCnt_r + 2'd1;
                    filtSum_r <= filtTotal;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Stall output
    // ------------------------------------------------------------
    // Follows the latest load value, one cycle behind it
    // Registered so the pin cannot glitch while the value settles
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stallOutput <= 1'b0;
        end else begin
            stallOutput <= (loadValue == 10'h000);               // see R6 R12
        end
    end

    // ------------------------------------------------------------
    // Thresholds
    // ------------------------------------------------------------
    // Bands scale by 32; upper sum peaks at 31, i.e. 992
    // Compared against the latest value, held between steps
    wire [9:0] lowerThresh = {1'b0, lowerBand, 5'b00000};        // see R3
    wire [4:0] upperSum    = {1'b0, lowerBand} + {1'b0, upperBandWidth}
                             + 5'd1;
    wire [9:0] upperThresh = {upperSum, 5'b00000};               // see R4
    wire       belowLower  = (loadValue < lowerThresh);
    wire       atOrAbove   = (loadValue >= upperThresh);

    // ------------------------------------------------------------
    // Current level adaptation
    // ------------------------------------------------------------
    // Floor is a quarter or half of the configured scale
    // Decrement pacing counts readings at or above the upper band
    reg  [5:0] downCnt_r;
    reg  [5:0] downCnt_nxt;
    reg  [5:0] level_nxt;
    wire [4:0] minLevel  = minCurrentHalf ? (currentScale >> 2)
                                          : (currentScale >> 1); // see R11
    wire [3:0] upStep    = 4'd1 << upStepWidth;                  // see R9
    wire [5:0] downMax   = downLimit(downRateCount);

    // ------------------------------------------------------------
    // Level update
    // ------------------------------------------------------------
    // Timing from a full step:
    //   edge 1  load value updated
    //   edge 2  level and stall follow
    // Next level and high-reading counter for each fresh value
    always @* begin
        level_nxt   = {1'b0, actualCurrentLevel};
        downCnt_nxt = downCnt_r;
        if (measDone_r) begin
            if (belowLower) begin
                level_nxt   = {1'b0, actualCurrentLevel}
                              + {2'b00, upStep};                 // see R3 R9
                downCnt_nxt = 6'd0;
            end else if (atOrAbove) begin
                if (downCnt_r + 6'd1 >= downMax) begin
                    downCnt_nxt = 6'd0;
                    if (actualCurrentLevel != 5'd0) begin
                        level_nxt = {1'b0, actualCurrentLevel}
                                    - 6'd1;                      // see R5 R10
                    end
                end else begin
                    downCnt_nxt = downCnt_r + 6'd1;              // see R5
                end
            end
        end
    end

    // Clamping runs every cycle so a new scale takes hold at once
    // Reset level equals the reset scale, full current
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            actualCurrentLevel <= `LACC_LEVEL_RST;
            downCnt_r          <= 6'd0;
        end else begin
            actualCurrentLevel <= clampLevel(level_nxt, minLevel,
                                             currentScale);      // see R11
            downCnt_r          <= downCnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    // Request decode; a pending ack blocks a second take
    wire        wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        ctrlHit = (wb_adr_i == `LACC_CTRL_ADDR);
    wire        statHit = (wb_adr_i == `LACC_STATUS_ADDR);
    wire        ctrlWr  = wbReq & wb_we_i & ctrlHit;
    wire [31:0] ctrlMerged;
    wire [31:0] statusWord;
    genvar      lane;

    // Read-only view; writes to it are dropped
    assign statusWord = {16'h0000, stallOutput, actualCurrentLevel,
                         loadValue};

    // ------------------------------------------------------------
    // Control write merge
    // ------------------------------------------------------------
    // One lane per byte enable; unselected bytes keep their value
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : gLane
            assign ctrlMerged[lane*8 +: 8] = (ctrlWr && wb_sel_i[lane])
                                             ? wb_dat_i[lane*8 +: 8]
                                             : ctrl_r[lane*8 +: 8];
        end
    endgenerate

    // Bits above the map always read 0
    always @* begin
        ctrl_nxt = ctrlMerged & `LACC_CTRL_MASK;
    end

    // ------------------------------------------------------------
    // Read and acknowledge
    // ------------------------------------------------------------
    // One-cycle answer; unmapped addresses ack and read zero
    // Write to status or unmapped space is dropped
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r   <= `LACC_CTRL_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ctrl_r   <= ctrl_nxt;
            wb_ack_o <= wbReq;
            if (wbReq && !wb_we_i) begin
                if (ctrlHit) begin
                    wb_dat_o <= ctrl_r;
                end else if (statHit) begin
                    wb_dat_o <= statusWord;
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

endmodule // lacc_top

/* File: test/lacc_motor_model.sv */
`timescale 1ns/1ns
// ----
// Motor side model
// ----
module lacc_motor_model (
    input  wire       clk,
    input  wire       rstn,
    input  wire       run,
    input  wire [1:0] gap,
    input  wire [9:0] loadSet,
    output reg        fullStep,
    output reg  [9:0] rawLoad
);
    reg [1:0] cnt_r;
    // One step per gap+1 cycles; gap 0 gives back-to-back steps
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r    <= 2'h0;
            fullStep <= 1'b0;
            rawLoad  <= 10'h000;
        end else begin
            fullStep <= run && (cnt_r == 2'h0);
            cnt_r    <= (cnt_r >= gap) ? 2'h0 : cnt_r + 2'h1;
            rawLoad  <= loadSet;
        end
    end
endmodule // lacc_motor_model

/* File: test/lacc_top_properties.sv */
`timescale 1ns/1ns
// ----
// Port checker
// ----
module lacc_top_checker #(
    parameter ADDR_W = 8
) (
    input wire              clk,
    input wire              rstn,
    input wire              wb_cyc_i,
    input wire              wb_stb_i,
    input wire              wb_we_i,
    input wire [ADDR_W-1:0] wb_adr_i,
    input wire [31:0]       wb_dat_o,
    input wire              wb_ack_o,
    input wire              fullStep,
    input wire [9:0]        loadValue,
    input wire [4:0]        actualCurrentLevel,
    input wire              stallOutput
);
    reg  [2:0] wrHold_r;
    wire       quiet;
    // Writes may clamp the level at once, so level checks pause
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            wrHold_r <= 3'h0;
        else if (wb_ack_o && wb_we_i)
            wrHold_r <= 3'h5;
        else if (wrHold_r != 3'h0)
            wrHold_r <= wrHold_r - 3'h1;
    end
    assign quiet = (wrHold_r == 3'h0) && !wb_ack_o;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    AST_ACK_RESP: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    AST_STALL_HI: assert property (loadValue == 10'h000 |=> stallOutput)
        else $error("stall missing");
    AST_STALL_LO: assert property (loadValue != 10'h000 |=> !stallOutput)
        else $error("false stall");
    AST_LOAD_STEP: assert property ($changed(loadValue) |-> $past(fullStep))
        else $error("load changed off step");
    AST_LVL_CAUSE: assert property (quiet && $changed(actualCurrentLevel)
        |-> $past(fullStep, 2))
        else $error("level changed without load");
    AST_LVL_UP: assert property (quiet && actualCurrentLevel > $past(actualCurrentLevel)
        |-> actualCurrentLevel - $past(actualCurrentLevel) <= 5'h08)
        else $error("level raised too far");
    AST_LVL_DN: assert property (quiet && actualCurrentLevel < $past(actualCurrentLevel)
        |-> $past(actualCurrentLevel) - actualCurrentLevel == 5'h01)
        else $error("level lowered by more than one");
    AST_STATUS: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == 8'h04 |=> wb_dat_o[15:0] ==
        $past({stallOutput, actualCurrentLevel, loadValue}))
        else $error("status read wrong");
endmodule // lacc_top_checker

bind lacc_top lacc_top_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fullStep(fullStep), .loadValue(loadValue),
    .actualCurrentLevel(actualCurrentLevel), .stallOutput(stallOutput));

/* File: test/load_adaptive_current_control_tb_top.sv */
`timescale 1ns/1ns
`include "lacc_map.vh"
module load_adaptive_current_control_tb_top;
    logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, run = 0, ack, fs, stall;
    logic        chkOn = 0, newL = 0, eStall = 0;
    logic [1:0]  gap = 2'h0;
    logic [3:0]  sel = 4'h0, wsel = 4'hF;
    logic [7:0]  adr = 8'h00;
    logic [9:0]  loadSet = 10'h000, raw, load, eLoad = 10'h3FF;
    logic [4:0]  lvl, eLvl = 5'h1F;
    logic [31:0] wdat = 0, rdat, q, cfg, ctrlM = 32'h03E0_0000;
    int          num_errors = 0, total_checks = 0, tick = 0;
    int          acc = 0, nAcc = 0, cnt = 0, lv, t, lo, hi, cand[6];
    int          dnTab[4] = '{32, 8, 2, 1};

    lacc_top dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .fullStep(fs), .rawLoad(raw), .loadValue(load), .actualCurrentLevel(lvl),
        .stallOutput(stall));
    lacc_motor_model u_mot (.clk(clk), .rstn(rstn), .run(run), .gap(gap),
        .loadSet(loadSet), .fullStep(fs), .rawLoad(raw));

    initial forever #5 clk = ~clk;

    function automatic int f(int lsb, int w);
        return (ctrlM >> lsb) & ((1 << w) - 1);
    endfunction
    // Signed trim scaled by 8, saturated to the 10-bit range
    function automatic int trm(int r);
        int v;
        v = r + 8 * $signed(ctrlM[6:0]);
        return (v < 0) ? 0 : ((v > 1023) ? 1023 : v);
    endfunction
    function automatic logic [4:0] clampLvl(int v);
        int mx, mn;
        mx = f(21, 5);
        mn = ctrlM[20] ? (mx >> 2) : (mx >> 1);
        v = (v > mx) ? mx : ((v < mn) ? mn : v);
        return v[4:0];
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task results;
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Classic cycle; entered just after a rising edge
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= wsel;
        @(negedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20)
            num_errors++;
        @(posedge clk);
        q = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
        if (w && a == 8'h00) begin
            if (wsel[0] && ctrlM[7] != d[7]) {acc, nAcc} = 0;
            for (int k = 0; k < 4; k++)
                if (wsel[k]) ctrlM[k*8 +: 8] = d[k*8 +: 8];
            ctrlM &= `LACC_CTRL_MASK;
        end
    endtask

    // Reference of load value, stall and adapted level
    always @(posedge clk) begin
        eStall <= (eLoad == 10'h000);
        lv = eLvl;
        if (newL && eLoad < f(8, 4) * 32) begin
            lv += 1 << f(16, 2);
            cnt = 0;
        end else if (newL && eLoad >= (f(8, 4) + f(12, 4) + 1) * 32) begin
            cnt++;
            if (cnt >= dnTab[f(18, 2)]) {lv, cnt} = {lv - 1, 32'd0};
        end
        eLvl <= clampLvl(lv);
        newL <= 0;
        if (fs === 1'b1) begin
            t = trm(raw);
            acc += t;
            nAcc++;
            if (!ctrlM[7] || nAcc == 4) begin
                eLoad <= ctrlM[7] ? 10'(acc >> 2) : 10'(t);
                newL <= 1;
                {acc, nAcc} = 0;
            end
        end
    end
    always @(negedge clk) if (rstn && chkOn) begin
        check("loadValue", load, eLoad);
        check("level", lvl, eLvl);
        check("stall", stall, eStall);
    end
    always @(posedge clk) if (++tick > 5000) begin
        num_errors++;
        results();
    end

    initial begin
        void'($urandom(83));
        repeat (12) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        wbx(0, 8'h00, 0);
        check("ctrlReset", q, 32'h03E0_0000);
        wbx(1, 8'h04, 32'hFFFF_FFFF);
        wbx(0, 8'h04, 0);
        check("statusReset", q, 32'h0000_7FFF);
        wbx(0, 8'h08, 0);
        check("unmapped", q, 0);
        wsel = 4'h2;
        wbx(1, 8'h00, 32'hFFFF_FFFF);
        wsel = 4'hF;
        wbx(0, 8'h00, 0);
        check("ctrlLane", q, 32'h03E0_FF00);
        for (int i = 0; i < 12; i++) begin
            chkOn = 0;
            cfg = $urandom;
            cfg[19:16] = {2'(i), 2'(i)};
            cfg[7] = i[0];
            if (i < 6) cfg[6:0] = 7'h00;
            wbx(1, 8'h00, cfg);
            wbx(0, 8'h00, 0);
            check("ctrl", q, ctrlM);
            lo = f(8, 4) * 32;
            hi = (f(8, 4) + f(12, 4) + 1) * 32;
            chkOn = 1;
            run <= 1;
            gap <= 2'(i >> 2);
            repeat (40) begin
                @(posedge clk);
                cand = '{0, lo - 1, lo, hi - 1, hi, $urandom % 1024};
                loadSet <= 10'(cand[$urandom % 6]);
            end
            run <= 0;
            repeat (4) @(posedge clk);
            wbx(0, 8'h04, 0);
            check("status", q, {16'h0000, eStall, eLvl, eLoad});
        end
        results();
    end
endmodule // load_adaptive_current_control_tb_top
